// ---- include/chg_term_pkg.sv ----
// Constants and carrier types for the charger termination and
// battery-short configuration block.
// Assumes a 50 MHz core clock and 8-bit register accesses.
package chg_term_pkg;

  // Core clock rate; one second of timeout is counted in these cycles.
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned SEC_UNIT_S = 1;
  localparam int unsigned CYC_PER_S  = CLK_HZ * SEC_UNIT_S;

  // Register addresses on the serial control bus.
  localparam logic [7:0] ADDR_FAULT     = 8'h0D;
  localparam logic [7:0] ADDR_BAT_SHORT = 8'h10;
  localparam logic [7:0] ADDR_TERM_CFG  = 8'h11;

  // Field positions.
  localparam int unsigned FLT_SHORT_BIT = 3;
  localparam int unsigned TMO_LSB       = 5;
  localparam int unsigned THR_LSB       = 0;
  localparam int unsigned TCODE_LSB     = 5;
  localparam int unsigned DIV20_BIT     = 4;
  localparam int unsigned DIV10_BIT     = 3;
  localparam int unsigned DIV5_BIT      = 2;
  localparam int unsigned SYSEN_LSB     = 0;

  // Reset values.
  localparam logic [2:0] TMO_RESET   = 3'h4;
  localparam logic [2:0] THR_RESET   = 3'h4;
  localparam logic [2:0] TCODE_RESET = 3'h2;
  localparam logic       DIV_RESET   = 1'b0;

  // Timeout codes in seconds, indexed by the timeout select code.
  localparam logic [7:0] TMO_SECONDS [8] = '{
    8'h01, 8'h02, 8'h04, 8'h0A, 8'h1E, 8'h3C, 8'h78, 8'hB4
  };

  // Termination currents in half-milliamp units, indexed by code.
  localparam logic [11:0] TERM_TABLE [8] = '{
    12'h019, 12'h041, 12'h069, 12'h091,
    12'h0B9, 12'h0EB, 12'h11D, 12'h154
  };
  localparam logic [11:0] TERM_MIN = 12'h019;
  localparam logic [11:0] TERM_MAX = 12'h154;

  // System-enable output modes.
  typedef enum logic [1:0] {
    SYSEN_LDO    = 2'b00,
    SYSEN_BATNODE = 2'b01,
    SYSEN_WEAKCUT = 2'b10,
    SYSEN_CHGWEAK = 2'b11
  } sysen_mode_e;
  localparam sysen_mode_e SYSEN_RESET = SYSEN_LDO;

  // Analog comparator levels that arrive from outside the clock domain.
  typedef struct packed {
    logic vin_present;
    logic ldo_active;
    logic sys_ok;
    logic node_ok;
    logic weak_ok;
    logic below_short;
  } sense_s;

endpackage

// ---- hdl/short_timer.sv ----
// Battery-short interval timer: counts whole seconds while the
// battery sits below the short threshold.
// Assumes a synchronised below-threshold level on the core clock.
`timescale 1ns/100ps
`default_nettype none
module short_timer #(
  parameter int unsigned CYC_PER_SEC = 50_000_000
) (
  input  wire logic       clk_i,       // Core clock.
  input  wire logic       rst_n_i,     // Async reset, active low.
  input  wire logic       ce_i,        // Clock enable.
  input  wire logic       below_i,     // Battery below threshold.
  input  wire logic [7:0] limit_s_i,   // Selected timeout in seconds.
  output logic            expired_o    // Whole interval spent below.
);

  localparam int unsigned PW = (CYC_PER_SEC > 1) ? $clog2(CYC_PER_SEC) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(CYC_PER_SEC - 1);

  logic [PW-1:0] presc_r;
  logic [PW-1:0] presc_nxt;
  logic [7:0]    secs_r;
  logic [7:0]    secs_nxt;
  logic          exp_r;
  logic          exp_nxt;

  // Any rise above the threshold restarts the interval from zero.
  always_comb begin
    presc_nxt = presc_r;
    secs_nxt  = secs_r;
    if (!below_i) begin
      presc_nxt = '0; // RL14
      secs_nxt  = '0;
    end else if (secs_r < limit_s_i) begin
      if (presc_r == PRESC_LAST) begin
        presc_nxt = '0;
        secs_nxt  = secs_r + 8'h01;
      end else begin
        presc_nxt = presc_r + PW'(1);
      end
    end
    exp_nxt = below_i && (secs_r >= limit_s_i); // RL14
  end

  // Counters freeze with the clock enable so timing pauses with it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_r <= '0;
      secs_r  <= '0;
      exp_r   <= 1'b0;
    end else if (ce_i) begin
      presc_r <= presc_nxt;
      secs_r  <= secs_nxt;
      exp_r   <= exp_nxt;
    end
  end

  assign expired_o = exp_r;

endmodule
`default_nettype wire

// ---- hdl/charger_termination_config.sv ----
// Termination and battery-short configuration registers with the
// selection logic behind them.
// Assumes the serial bus decoder presents byte accesses on the core
// clock; comparator levels arrive asynchronously and are synchronised.
//
// What this block does
// [RL1] The timeout select field in bits 7..5 picks 1 to 180 s and resets to 30 s.
// [RL2] The threshold select field in bits 2..0 picks 2.0 to 2.7 V and resets to 2.4 V.
// [RL3] The termination code in bits 7..5 picks 12.5 to 170 mA, resets to 52.5 mA, used only with no ratio bit set.
// [RL4] The divide-by-twenty bit 4 gives charge current over 20, clamped, above all else.
// [RL5] The divide-by-ten bit 3 gives charge current over 10, clamped, unless bit 4 is set.
// [RL6] The divide-by-five bit 2 gives charge current over 5, clamped, unless bit 4 or 3 is set.
// [RL7] Mode 00 drives system enable while the regulator is active and system voltage is present.
// [RL8] Mode 01 drives system enable from the battery-side node level.
// [RL9] Mode 10 drives system enable and opens the isolation switch once the battery is weak.
// [RL10] Mode 10 acts only with the input supply absent and the battery monitor enabled.
// [RL11] Mode 11 enables in regulator mode when charging is off, else only at or above weak level.
// [RL12] A detected battery short sets fault bit 3, which reads 0 without a fault.
// [RL13] Fault flags hold until software writes a one to them or the input supply is cycled.
// [RL14] A short is declared only after the full timeout below threshold, restarting on any rise.
// [RL15] Bits 4 and 3 of the battery-short register read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
module charger_termination_config
  import chg_term_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CYC_PER_S
) (
  input  wire logic        core_clk_i,            // Core clock, 50 MHz.
  input  wire logic        rst_n_i,               // Async reset, low.
  input  wire logic        ce_i,                  // Freezes state when low.
  input  wire logic [7:0]  reg_addr_i,            // Register address.
  input  wire logic [7:0]  reg_wdata_i,           // Write data.
  input  wire logic        reg_wr_i,              // Write strobe.
  input  wire logic        reg_rd_i,              // Read strobe.
  output logic      [7:0]  reg_rdata_o,           // Read data, next cycle.
  input  wire sense_s      sense_i,               // Async comparator levels.
  input  wire logic        charge_enabled_i,      // Charger on, same clock.
  input  wire logic        battery_monitor_enable_i, // Monitor bit.
  input  wire logic [11:0] charge_current_setting_i, // In 0.5 mA units.
  output logic      [11:0] term_current_o,        // In 0.5 mA units.
  output logic      [2:0]  short_threshold_sel_o, // To short comparator.
  output logic             system_enable_out_o,   // System enable pin.
  output logic             iso_fet_off_o,         // Opens isolation switch.
  output logic             battery_short_fault_o  // Short fault flag.
);

  // Two-stage synchroniser; stage one feeds only stage two.
  sense_s sync1_r;
  sense_s sync2_r;
  sense_s sync1_nxt;
  sense_s sync2_nxt;
  logic   vin_prev_r;
  logic   vin_prev_nxt;

  always_comb begin
    sync1_nxt    = sense_i;
    sync2_nxt    = sync1_r;
    vin_prev_nxt = sync2_r.vin_present;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      vin_prev_r <= 1'b0;
    end else if (ce_i) begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      vin_prev_r <= vin_prev_nxt;
    end
  end

  // Software-written configuration fields.
  logic [2:0]  tmo_r, tmo_nxt;
  logic [2:0]  thr_r, thr_nxt;
  logic [2:0]  tcode_r, tcode_nxt;
  logic        div20_r, div20_nxt;
  logic        div10_r, div10_nxt;
  logic        div5_r, div5_nxt;
  sysen_mode_e mode_r, mode_nxt;
  logic        fault_r, fault_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        expired;
  logic        wr_short;
  logic        wr_term;
  logic        wr_fault;
  logic        vin_return;

  assign wr_short   = reg_wr_i && (reg_addr_i == ADDR_BAT_SHORT);
  assign wr_term    = reg_wr_i && (reg_addr_i == ADDR_TERM_CFG);
  assign wr_fault   = reg_wr_i && (reg_addr_i == ADDR_FAULT);
  assign vin_return = sync2_r.vin_present && !vin_prev_r;

  short_timer #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_timer (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .below_i   (sync2_r.below_short),
    .limit_s_i (TMO_SECONDS[tmo_r]),
    .expired_o (expired)
  );

  // Register writes, fault flag and read-back. Bits 4..3 of the short
  // register are not stored, so they cannot read back nonzero.
  always_comb begin
    tmo_nxt   = tmo_r;
    thr_nxt   = thr_r;
    tcode_nxt = tcode_r;
    div20_nxt = div20_r;
    div10_nxt = div10_r;
    div5_nxt  = div5_r;
    mode_nxt  = mode_r;
    rdata_nxt = rdata_r;
    if (wr_short) begin
      tmo_nxt = reg_wdata_i[TMO_LSB +: 3]; // RL1
      thr_nxt = reg_wdata_i[THR_LSB +: 3]; // RL2
    end
    if (wr_term) begin
      tcode_nxt = reg_wdata_i[TCODE_LSB +: 3]; // RL3
      div20_nxt = reg_wdata_i[DIV20_BIT];
      div10_nxt = reg_wdata_i[DIV10_BIT];
      div5_nxt  = reg_wdata_i[DIV5_BIT];
      mode_nxt  = sysen_mode_e'(reg_wdata_i[SYSEN_LSB +: 2]);
    end
    // A clear by write or supply return loses to a short seen now.
    fault_nxt = fault_r;
    if ((wr_fault && reg_wdata_i[FLT_SHORT_BIT]) || vin_return) begin
      fault_nxt = 1'b0; // RL13
    end
    if (expired) begin
      fault_nxt = 1'b1; // RL12
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_FAULT:     rdata_nxt = 8'(fault_r) << FLT_SHORT_BIT; // RL12
        ADDR_BAT_SHORT: rdata_nxt = {tmo_r, 2'b00, thr_r}; // RL15
        ADDR_TERM_CFG:  rdata_nxt = {tcode_r, div20_r, div10_r, div5_r,
                                     mode_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_r   <= TMO_RESET;   // RL1
      thr_r   <= THR_RESET;   // RL2
      tcode_r <= TCODE_RESET; // RL3
      div20_r <= DIV_RESET;
      div10_r <= DIV_RESET;
      div5_r  <= DIV_RESET;
      mode_r  <= SYSEN_RESET;
      fault_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      tmo_r   <= tmo_nxt;
      thr_r   <= thr_nxt;
      tcode_r <= tcode_nxt;
      div20_r <= div20_nxt;
      div10_r <= div10_nxt;
      div5_r  <= div5_nxt;
      mode_r  <= mode_nxt;
      fault_r <= fault_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Clamp a ratio current into the allowed termination window.
  function automatic logic [11:0] clamp_term(input logic [11:0] v);
    if (v < TERM_MIN) begin
      clamp_term = TERM_MIN;
    end else if (v > TERM_MAX) begin
      clamp_term = TERM_MAX;
    end else begin
      clamp_term = v;
    end
  endfunction

  // Termination current and system-enable selection.
  logic [11:0] term_r, term_nxt;
  logic        sysen_r, sysen_nxt;
  logic        isooff_r, isooff_nxt;
  logic        cut_armed;

  assign cut_armed = !sync2_r.vin_present && battery_monitor_enable_i;

  always_comb begin
    // Fixed priority: twenty, then ten, then five, then the code.
    if (div20_r) begin
      term_nxt = clamp_term(charge_current_setting_i / 12'd20); // RL4
    end else if (div10_r) begin
      term_nxt = clamp_term(charge_current_setting_i / 12'd10); // RL5
    end else if (div5_r) begin
      term_nxt = clamp_term(charge_current_setting_i / 12'd5); // RL6
    end else begin
      term_nxt = TERM_TABLE[tcode_r]; // RL3
    end
    isooff_nxt = 1'b0;
    case (mode_r)
      SYSEN_LDO: begin
        sysen_nxt = sync2_r.ldo_active && sync2_r.sys_ok; // RL7
      end
      SYSEN_BATNODE: begin
        sysen_nxt = sync2_r.node_ok; // RL8
      end
      SYSEN_WEAKCUT: begin
        // Outside its window this mode leaves the pin low.
        sysen_nxt  = cut_armed && !sync2_r.weak_ok; // RL9 RL10
        isooff_nxt = cut_armed && !sync2_r.weak_ok; // RL9 RL10
      end
      SYSEN_CHGWEAK: begin
        sysen_nxt = charge_enabled_i ? sync2_r.weak_ok
                                     : sync2_r.ldo_active; // RL11
      end
      default: begin
        sysen_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_r   <= TERM_TABLE[TCODE_RESET];
      sysen_r  <= 1'b0;
      isooff_r <= 1'b0;
    end else if (ce_i) begin
      term_r   <= term_nxt;
      sysen_r  <= sysen_nxt;
      isooff_r <= isooff_nxt;
    end
  end

  assign reg_rdata_o           = rdata_r;
  assign term_current_o        = term_r;
  assign short_threshold_sel_o = thr_r;
  assign system_enable_out_o   = sysen_r;
  assign iso_fet_off_o         = isooff_r;
  assign battery_short_fault_o = fault_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_term_write;
    ce_i && wr_term;
  endsequence

  div20_pick_a: assert property (ce_i && div20_r |=> // RL4
    term_r == clamp_term($past(charge_current_setting_i) / 12'd20))
    else $error("Divide-by-twenty termination current wrong.");
  div10_pick_a: assert property (ce_i && !div20_r && div10_r |=> // RL5
    term_r == clamp_term($past(charge_current_setting_i) / 12'd10))
    else $error("Divide-by-ten termination current wrong.");
  div5_pick_a: assert property (ce_i && !div20_r && !div10_r && div5_r |=>
    term_r == clamp_term($past(charge_current_setting_i) / 12'd5)) // RL6
    else $error("Divide-by-five termination current wrong.");
  code_table_a: assert property (s_term_write ##1 ce_i && // RL3
    !div20_r && !div10_r && !div5_r |=> term_r == TERM_TABLE[$past(tcode_r)])
    else $error("Fixed termination code not applied.");
  short_reserved_a: assert property (ce_i && reg_rd_i && // RL15
    reg_addr_i == ADDR_BAT_SHORT |=> reg_rdata_o[4:3] == 2'b00)
    else $error("Unused short register bits read nonzero.");
  short_readback_a: assert property (ce_i && wr_short ##1 ce_i && reg_rd_i &&
    reg_addr_i == ADDR_BAT_SHORT |=> reg_rdata_o[7:5] == $past(tmo_r,1) &&
    reg_rdata_o[2:0] == $past(thr_r,1)) // RL1
    else $error("Short register read-back mismatch.");
  ldo_mode_a: assert property (ce_i && mode_r == SYSEN_LDO |=> // RL7
    system_enable_out_o == ($past(sync2_r.ldo_active) && $past(sync2_r.sys_ok)))
    else $error("Regulator-mode system enable wrong.");
  weak_cut_a: assert property (ce_i && mode_r == SYSEN_WEAKCUT |=> // RL10
    iso_fet_off_o == ($past(cut_armed) && !$past(sync2_r.weak_ok)))
    else $error("Weak-battery cut gating wrong.");
  chg_weak_a: assert property (ce_i && mode_r == SYSEN_CHGWEAK && // RL11
    charge_enabled_i |=> system_enable_out_o == $past(sync2_r.weak_ok))
    else $error("Charging-mode system enable wrong.");
  fault_set_a: assert property (ce_i && expired |=> // RL12
    battery_short_fault_o ##1 (battery_short_fault_o || !ce_i || expired ||
    $past(wr_fault) || $past(vin_return)))
    else $error("Short fault not set or lost.");
  fault_hold_a: assert property (ce_i && fault_r && !expired && // RL13
    !wr_fault && !vin_return |=> battery_short_fault_o)
    else $error("Fault flag dropped without a clear.");

endmodule
`default_nettype wire

// ---- bench/cell_rail_model.sv ----
// Battery cell and system rail model: turns rail states and a battery
// voltage into the comparator levels that the block sees.
// Assumes the bench drives millivolt levels on the core clock.
`timescale 1ns/100ps
`default_nettype none
module cell_rail_model
  import chg_term_pkg::*;
(
  input  wire logic        vin_on_i,  // Input supply present.
  input  wire logic        ldo_on_i,  // Regulator running.
  input  wire logic        sys_on_i,  // System rail present.
  input  wire logic [11:0] bat_mv_i,  // Battery voltage in mV.
  input  wire logic [2:0]  thr_sel_i, // Short threshold code.
  output var  sense_s      sense_o    // Comparator levels.
);
  localparam logic [11:0] WEAK_MV = 12'hBB8; // Weak level, 3000 mV.
  localparam logic [11:0] NODE_MV = 12'h9C4; // Node level, 2500 mV.
  logic [11:0] short_mv;

  // The short comparator follows the block's threshold code, so a wrong
  // code shows up as a wrong detection.
  assign short_mv = 12'h7D0 + 12'(thr_sel_i) * 12'h064;

  // Removing the supply is how the cell side power-cycles the flags.
  assign sense_o = '{vin_present: vin_on_i,
                     ldo_active:  ldo_on_i,
                     sys_ok:      sys_on_i,
                     node_ok:     bat_mv_i >= NODE_MV,
                     weak_ok:     bat_mv_i >= WEAK_MV,
                     below_short: bat_mv_i < short_mv};
endmodule
`default_nettype wire

// ---- bench/test_charger_termination_config.sv ----
// Self-checking bench for the termination and battery-short registers.
// Assumes one second is shortened to four core clock cycles.
`timescale 1ns/100ps
`default_nettype none
module test_charger_termination_config;
  import chg_term_pkg::*;
  logic        core_clk_i;
  logic        rst_n_i;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, chg_en, mon_en, vin, ldo, sysr;
  logic        ce;
  logic [11:0] charge_current_setting, term, bat;
  logic [2:0]  thr;
  logic        sysen, iso, fault;
  sense_s      sense;
  int          fail_count = 0;
  int          check_count = 0;
  logic [11:0] code_tbl [8] = '{12'h019, 12'h041, 12'h069, 12'h091,
                                12'h0B9, 12'h0EB, 12'h11D, 12'h154};

  charger_termination_config #(.CYC_PER_SEC(4)) charger_termination_config_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .sense_i(sense), .charge_enabled_i(chg_en),
    .battery_monitor_enable_i(mon_en), .charge_current_setting_i(charge_current_setting),
    .term_current_o(term), .short_threshold_sel_o(thr),
    .system_enable_out_o(sysen), .iso_fet_off_o(iso),
    .battery_short_fault_o(fault));

  cell_rail_model cell_rail_model_inst (
    .vin_on_i(vin), .ldo_on_i(ldo), .sys_on_i(sysr), .bat_mv_i(bat),
    .thr_sel_i(thr), .sense_o(sense));

  // Free-running 50 MHz core clock.
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n edges and steps past them so registered outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
  endtask

  task automatic set_bat(input logic [11:0] mv);
    @(posedge core_clk_i);
    bat <= mv;
  endtask

  task automatic t_reset();
    rd_reg(ADDR_BAT_SHORT, 8'h84);
    rd_reg(ADDR_TERM_CFG, 8'h40);
    chk(term, 12'h069);
    chk({9'h000, thr}, 12'h004);
  endtask

  // The unused middle bits must drop out of a full write.
  task automatic t_short_reg();
    wr_reg(ADDR_BAT_SHORT, 8'hFF);
    rd_reg(ADDR_BAT_SHORT, 8'hE7);
    tick(2);
    chk({9'h000, thr}, 12'h007);
  endtask

  // A write made while the clock enable is low must leave no trace.
  task automatic t_freeze();
    @(posedge core_clk_i);
    ce <= 1'b0;
    wr_reg(ADDR_BAT_SHORT, 8'h00);
    @(posedge core_clk_i);
    ce <= 1'b1;
    rd_reg(ADDR_BAT_SHORT, 8'hE7);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      wr_reg(ADDR_TERM_CFG, {3'(i), 5'h00});
      tick(2);
      chk(term, code_tbl[i]);
    end
  endtask

  task automatic t_ratio(input logic [11:0] c, input logic [7:0] d,
                         input logic [11:0] exp);
    @(posedge core_clk_i);
    charge_current_setting <= c;
    wr_reg(ADDR_TERM_CFG, d);
    tick(2);
    chk(term, exp);
  endtask

  // Each row sets the rails, then checks enable and isolation together.
  task automatic t_env(input logic [1:0] m, input logic v, input logic l,
                       input logic s, input logic c, input logic mo,
                       input logic [11:0] b, input logic [1:0] exp);
    @(posedge core_clk_i);
    vin    <= v;
    ldo    <= l;
    sysr   <= s;
    chg_en <= c;
    mon_en <= mo;
    bat    <= b;
    wr_reg(ADDR_TERM_CFG, {6'h10, m});
    tick(4);
    chk({10'h000, sysen, iso}, {10'h000, exp});
  endtask

  // One-second timeout and 2.0 V threshold; a short dip must not count.
  task automatic t_short();
    int n;
    wr_reg(ADDR_BAT_SHORT, 8'h00);
    set_bat(12'h76C);
    set_bat(12'h9C4);
    tick(10);
    chk({11'h000, fault}, 12'h000);
    set_bat(12'h76C);
    tick(4);
    chk({11'h000, fault}, 12'h000);
    n = 0;
    while (fault !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk({11'h000, fault}, 12'h001);
    rd_reg(ADDR_FAULT, 8'h08);
    set_bat(12'h9C4);
    wr_reg(ADDR_FAULT, 8'h00);
    tick(4);
    chk({11'h000, fault}, 12'h001);
    wr_reg(ADDR_FAULT, 8'h08);
    rd_reg(ADDR_FAULT, 8'h00);
    set_bat(12'h76C);
    tick(12);
    set_bat(12'h9C4);
    chk({11'h000, fault}, 12'h001);
    @(posedge core_clk_i);
    vin <= 1'b0;
    tick(4);
    @(posedge core_clk_i);
    vin <= 1'b1;
    tick(6);
    chk({11'h000, fault}, 12'h000);
  endtask

  // A hang is cut off well beyond the few hundred cycles the run needs.
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    {addr, wdata, wr, rd, chg_en, mon_en} = '0;
    ce = 1'b1;
    {vin, ldo, sysr} = 3'b111;
    charge_current_setting = 12'h3E8;
    bat  = 12'hCE4;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    t_reset();
    t_short_reg();
    t_freeze();
    t_codes();
    t_ratio(12'h3E8, 8'hFC, 12'h032);
    t_ratio(12'h3E8, 8'hEC, 12'h064);
    t_ratio(12'h3E8, 8'hE4, 12'h0C8);
    t_ratio(12'hBB8, 8'h04, 12'h154);
    t_ratio(12'h064, 8'h10, 12'h019);
    t_env(2'b00, 1, 1, 1, 0, 0, 12'hCE4, 2'b10);
    t_env(2'b00, 1, 1, 0, 0, 0, 12'hCE4, 2'b00);
    t_env(2'b01, 1, 1, 1, 0, 0, 12'hCE4, 2'b10);
    t_env(2'b01, 1, 1, 1, 0, 0, 12'h898, 2'b00);
    t_env(2'b10, 0, 0, 1, 0, 1, 12'hAF0, 2'b11);
    t_env(2'b10, 1, 1, 1, 0, 1, 12'hAF0, 2'b00);
    t_env(2'b10, 0, 0, 1, 0, 0, 12'hAF0, 2'b00);
    t_env(2'b10, 0, 0, 1, 0, 1, 12'hCE4, 2'b00);
    t_env(2'b11, 1, 1, 1, 0, 0, 12'hAF0, 2'b10);
    t_env(2'b11, 1, 0, 1, 0, 0, 12'hCE4, 2'b00);
    t_env(2'b11, 1, 1, 1, 1, 0, 12'hCE4, 2'b10);
    t_env(2'b11, 1, 1, 1, 1, 0, 12'hAF0, 2'b00);
    t_short();
    wrap_up();
  end
endmodule
`default_nettype wire
